// ==== inc/sfb_pkg.sv ====
// Overview of operation
// RL1 - A write to the erase trigger starts a mass or page flash erase.
// RL2 - Erase page number holds page 0 to 127, zero after reset.
// RL3 - Software rewrites the page number before each new page erase.
// RL4 - Program write enable redirects accumulator-to-pointer moves from data RAM to flash.
// RL5 - Mass erase needs the write-only enable bit; software resets it each time; the code clears it on every erase trigger write.
// RL6 - Readout lock clears on reset, set-only, and blocks external flash reads.
// RL7 - Read-only status bit shows the boot prelude is running.
// RL8 - Transfer flag set by hardware on transfer-busy interrupt, handler clears it.
// RL9 - Seconds-tick flag set on each one-second interrupt, handler clears it.
// RL10 - Collision flag set when flash write runs while compute engine busy.
// RL11 - Collision flag set when flash write attempted as engine starts a pass.
// RL12 - Button flag set when the wake-up push-button is pressed.
// RL13 - Autowake flag set when the autowake timer wakes the processor.
// RL14 - Separate lock rise and fall flags; writing 0 clears a flag.
// RL15 - Seven read-only bits show live external interrupt input levels.
// RL16 - Writing 1 to the watchdog restart bit resets the watchdog.
// RL17 - Software clears flags by whole-register writes with other bits at one.
// RL18 - Writing 1 to a flag bit leaves it unchanged.
// RL19 - Erase trigger does mass erase if enabled, else erases the stored page.
`default_nettype none
package sfb_pkg;
  localparam logic [7:0] ADDR_ERASE_TRIGGER = 8'h94;
  localparam logic [7:0] ADDR_EEPROM_DATA   = 8'h9e;
  localparam logic [7:0] ADDR_EEPROM_CTRL   = 8'h9f;
  localparam logic [7:0] ADDR_FLASH_CONTROL = 8'hb2;
  localparam logic [7:0] ADDR_BANK_SELECT   = 8'hb6;
  localparam logic [7:0] ADDR_ERASE_PAGE    = 8'hb7;
  localparam logic [7:0] ADDR_EVENT_FLAGS   = 8'he8;
  localparam logic [7:0] ADDR_EXT_IRQ_VIEW  = 8'hf8;
  localparam int BIT_PWE     = 0;
  localparam int BIT_MEEN    = 1;
  localparam int BIT_LOCK    = 6;
  localparam int BIT_PRELUDE = 7;
  localparam int BIT_DOG     = 7;
  localparam int BANK_W      = 3;
  localparam int NUM_FLAGS   = 8;
  localparam int NUM_EXT_IRQ = 7;
  localparam logic [7:0] ERASE_PAGE_MAX   = 8'h7f;
  localparam logic [7:0] RST_ERASE_PAGE   = 8'h00;
  localparam logic [7:0] RST_FLAGS        = 8'h00;
  localparam logic [7:0] RST_EEPROM       = 8'h00;
  localparam logic [BANK_W-1:0] RST_BANK  = 3'h0;
endpackage : sfb_pkg
`default_nettype wire

// ==== hw/sfb_sync.sv ====
`timescale 1ns/1ps
`default_nettype none
module sfb_sync #(
  parameter int W = 1
) (
  input  wire logic         sys_clk,
  input  wire logic         arst_n,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] meta_q;
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_q   <= '0;
      sync_out <= '0;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule // sfb_sync
`default_nettype wire

// ==== hw/sfb_sfr_bank.sv ====
`timescale 1ns/1ps
`default_nettype none
module sfb_sfr_bank
  import sfb_pkg::*;
(
  input  wire logic                           sys_clk,
  input  wire logic                           arst_n,
  input  wire logic [7:0]                     sfr_addr,
  input  wire logic                           sfr_wr,
  input  wire logic                           sfr_rd,
  input  wire logic [7:0]                     sfr_wdata,
  output logic      [7:0]                     sfr_rdata,
  input  wire logic                           prelude_active,
  input  wire logic                           transfer_busy_irq,
  input  wire logic                           seconds_tick_irq,
  input  wire logic                           write_busy_collision,
  input  wire logic                           write_start_collision,
  input  wire logic                           button_pressed,
  input  wire logic                           autowake_event,
  input  wire logic                           clk_lock_level,
  input  wire logic [sfb_pkg::NUM_EXT_IRQ-1:0] ext_irq_levels,
  output logic                                mass_erase_start,
  output logic                                page_erase_start,
  output logic      [7:0]                     erase_page_number,
  output logic                                program_write_enable,
  output logic                                readout_lock,
  output logic      [sfb_pkg::BANK_W-1:0]     flash_bank_select,
  output logic                                watchdog_restart,
  output logic      [7:0]                     eeprom_link_data,
  output logic      [7:0]                     eeprom_link_control
);
  import sfb_pkg::*;

  logic [NUM_EXT_IRQ-1:0] ext_sync;
  logic [5:0]             evt_sync;
  logic                   lock_prev_q;
  logic                   mass_enable_q;
  logic [7:0]             flags_q;
  logic [7:0]             flags_d;
  logic [7:0]             flag_set;

  sfb_sync #(.W(NUM_EXT_IRQ)) u_ext_sync (
    .sys_clk (sys_clk),
    .arst_n  (arst_n),
    .async_in(ext_irq_levels),
    .sync_out(ext_sync)
  );

  sfb_sync #(.W(6)) u_evt_sync (
    .sys_clk (sys_clk),
    .arst_n  (arst_n),
    .async_in({clk_lock_level, autowake_event, button_pressed, prelude_active,
               write_start_collision, write_busy_collision}),
    .sync_out(evt_sync)
  );

  wire lock_sync    = evt_sync[5];
  wire prelude_sync = evt_sync[2];

  function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
    return a == r;
  endfunction

  wire wr_erase = sfr_wr && hit(sfr_addr, ADDR_ERASE_TRIGGER);
  wire wr_ctrl  = sfr_wr && hit(sfr_addr, ADDR_FLASH_CONTROL);
  wire wr_bank  = sfr_wr && hit(sfr_addr, ADDR_BANK_SELECT);
  wire wr_page  = sfr_wr && hit(sfr_addr, ADDR_ERASE_PAGE);
  wire wr_flags = sfr_wr && hit(sfr_addr, ADDR_EVENT_FLAGS);
  wire wr_view  = sfr_wr && hit(sfr_addr, ADDR_EXT_IRQ_VIEW);
  wire wr_eed   = sfr_wr && hit(sfr_addr, ADDR_EEPROM_DATA);
  wire wr_eec   = sfr_wr && hit(sfr_addr, ADDR_EEPROM_CTRL);

  // Hardware set sources, bit order matches the flag register
  assign flag_set = {
    ~lock_sync & lock_prev_q,        // RL14
    lock_sync & ~lock_prev_q,        // RL14
    evt_sync[4],                     // RL13
    evt_sync[3],                     // RL12
    evt_sync[1],                     // RL11
    evt_sync[0],                     // RL10
    seconds_tick_irq,                // RL9
    transfer_busy_irq                // RL8
  };

  // Set wins; written 0 clears, written 1 keeps
  genvar g;
  generate
    for (g = 0; g < NUM_FLAGS; g++) begin : g_flag
      assign flags_d[g] = flag_set[g] |
                          (flags_q[g] & ~(wr_flags & ~sfr_wdata[g])); // RL14 RL18
    end
  endgenerate

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      flags_q     <= RST_FLAGS;
      lock_prev_q <= 1'b0;
    end else begin
      flags_q     <= flags_d; // RL8 RL9
      lock_prev_q <= lock_sync;
    end
  end

  // Control register
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      program_write_enable <= 1'b0;
      mass_enable_q        <= 1'b0;
      readout_lock         <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        program_write_enable <= sfr_wdata[BIT_PWE]; // RL4
        mass_enable_q        <= sfr_wdata[BIT_MEEN]; // RL5
      end else if (wr_erase) begin
        mass_enable_q        <= 1'b0; // RL5
      end
      if (wr_ctrl && sfr_wdata[BIT_LOCK]) begin
        readout_lock <= 1'b1; // RL6
      end
    end
  end

  // Erase page, bank, eeprom holding registers
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      erase_page_number   <= RST_ERASE_PAGE;
      flash_bank_select   <= RST_BANK;
      eeprom_link_data    <= RST_EEPROM;
      eeprom_link_control <= RST_EEPROM;
    end else begin
      if (wr_page) begin
        erase_page_number <= sfr_wdata & ERASE_PAGE_MAX; // RL2
      end
      if (wr_bank) begin
        flash_bank_select <= sfr_wdata[BANK_W-1:0];
      end
      if (wr_eed) begin
        eeprom_link_data <= sfr_wdata;
      end
      if (wr_eec) begin
        eeprom_link_control <= sfr_wdata;
      end
    end
  end

  // Erase start and watchdog pulses
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      mass_erase_start <= 1'b0;
      page_erase_start <= 1'b0;
      watchdog_restart <= 1'b0;
    end else begin
      mass_erase_start <= wr_erase & mass_enable_q;  // RL1 RL19 RL5
      page_erase_start <= wr_erase & ~mass_enable_q; // RL1 RL19
      watchdog_restart <= wr_view & sfr_wdata[BIT_DOG]; // RL16
    end
  end

  // Read mux, registered
  logic [7:0] rd_mux;
  always_comb begin
    rd_mux = 8'h00;
    case (sfr_addr)
      ADDR_FLASH_CONTROL: begin
        rd_mux[BIT_PWE]     = program_write_enable;
        rd_mux[BIT_LOCK]    = readout_lock;
        rd_mux[BIT_PRELUDE] = prelude_sync; // RL7
      end
      ADDR_BANK_SELECT:  rd_mux = {{(8-BANK_W){1'b0}}, flash_bank_select};
      ADDR_ERASE_PAGE:   rd_mux = erase_page_number;
      ADDR_EVENT_FLAGS:  rd_mux = flags_q;
      ADDR_EXT_IRQ_VIEW: rd_mux = {1'b0, ext_sync}; // RL15
      ADDR_EEPROM_DATA:  rd_mux = eeprom_link_data;
      ADDR_EEPROM_CTRL:  rd_mux = eeprom_link_control;
      default:           rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      sfr_rdata <= 8'h00;
    end else if (sfr_rd) begin
      sfr_rdata <= rd_mux;
    end
  end
endmodule // sfb_sfr_bank
`default_nettype wire

// ==== dv/sfb_sfr_bank_assertions.sv ====
`timescale 1ns/1ps
`default_nettype none
module sfb_sfr_bank_chk (
  input wire logic       sys_clk,
  input wire logic       arst_n,
  input wire logic [7:0] sfr_addr,
  input wire logic       sfr_wr,
  input wire logic [7:0] sfr_wdata,
  input wire logic       mass_erase_start,
  input wire logic       page_erase_start,
  input wire logic [7:0] erase_page_number,
  input wire logic       program_write_enable,
  input wire logic       readout_lock,
  input wire logic       watchdog_restart
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  wire erw = sfr_wr && sfr_addr == 8'h94;
  wire ctw = sfr_wr && sfr_addr == 8'hb2;
  erase_start_a: assert property (erw |=> mass_erase_start || page_erase_start)
    else $error("erase write gave no pulse");
  erase_cause_a: assert property (page_erase_start |-> $past(erw))
    else $error("page erase without a trigger write");
  erase_one_a: assert property (!(mass_erase_start && page_erase_start))
    else $error("both erase kinds at once");
  page_store_a: assert property (sfr_wr && sfr_addr == 8'hb7 |=>
    erase_page_number == ($past(sfr_wdata) & 8'h7f)) else $error("page number not stored");
  pwe_store_a: assert property (ctw |=> program_write_enable == $past(sfr_wdata[0]))
    else $error("write enable not stored");
  lock_hold_a: assert property (readout_lock |=> readout_lock)
    else $error("lock cleared");
  lock_set_a: assert property (ctw && sfr_wdata[6] |=> readout_lock)
    else $error("lock not set");
  dog_kick_a: assert property (sfr_wr && sfr_addr == 8'hf8 && sfr_wdata[7] |=> watchdog_restart)
    else $error("no watchdog restart");
  cover property (mass_erase_start);
  cover property (page_erase_start);
  cover property (watchdog_restart);
endmodule // sfb_sfr_bank_chk
bind sfb_sfr_bank sfb_sfr_bank_chk u_chk (.sys_clk, .arst_n, .sfr_addr, .sfr_wr, .sfr_wdata,
  .mass_erase_start, .page_erase_start, .erase_page_number, .program_write_enable,
  .readout_lock, .watchdog_restart);
`default_nettype wire

// ==== dv/test_sfb_sfr_bank.sv ====
`timescale 1ns/1ps
`default_nettype none
module test_sfb_sfr_bank;
  import sfb_pkg::*;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, erase_page_number, v;
  logic [7:0] eeprom_link_data, eeprom_link_control;
  logic [6:0] ext_irq_levels;
  logic [2:0] flash_bank_select;
  logic       sys_clk, arst_n, sfr_wr, sfr_rd, prelude_active, transfer_busy_irq, rd_seen;
  logic       seconds_tick_irq, write_busy_collision, write_start_collision, button_pressed;
  logic       autowake_event, clk_lock_level, mass_erase_start, page_erase_start;
  logic       program_write_enable, readout_lock, watchdog_restart;
  int         errors, samples_checked, mass_n, page_n, dog_n;
  int         seed = 32'h70ab;
  logic [7:0] exp_q[$];
  sfb_sfr_bank dut (.sys_clk, .arst_n, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata,
    .prelude_active, .transfer_busy_irq, .seconds_tick_irq, .write_busy_collision,
    .write_start_collision, .button_pressed, .autowake_event, .clk_lock_level,
    .ext_irq_levels, .mass_erase_start, .page_erase_start, .erase_page_number,
    .program_write_enable, .readout_lock, .flash_bank_select, .watchdog_restart,
    .eeprom_link_data, .eeprom_link_control);
  initial begin
    sys_clk = 0;
    forever #5 sys_clk = ~sys_clk;
  end
  task automatic chk(logic [7:0] seen, logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic op(logic w, logic r, logic [7:0] a, logic [7:0] d);
    @(posedge sys_clk);
    #1 {sfr_wr, sfr_rd, sfr_addr, sfr_wdata} = {w, r, a, d};
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] e);
    exp_q.push_back(e);
    op(0, 1, a, 8'h00);
  endtask
  task automatic idle(int n);
    repeat (n) op(0, 0, 8'h00, 8'h00);
  endtask
  task automatic final_report;
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Read result check, one cycle after the read strobe
  always @(posedge sys_clk) rd_seen <= sfr_rd;
  always @(negedge sys_clk) begin
    if (rd_seen) chk(sfr_rdata, exp_q.pop_front());
    mass_n += mass_erase_start;
    page_n += page_erase_start;
    dog_n += watchdog_restart;
  end
  initial begin
    {arst_n, sfr_wr, sfr_rd, sfr_addr, sfr_wdata, prelude_active} = '0;
    {transfer_busy_irq, seconds_tick_irq, write_busy_collision, write_start_collision} = '0;
    {button_pressed, autowake_event, clk_lock_level, ext_irq_levels} = '0;
    repeat (5) @(posedge sys_clk);
    #1 arst_n = 1;
    rd(8'hb7, 8'h00);
    rd(8'he8, 8'h00);
    rd(8'h00, 8'h00);
    v = 8'($random(seed));
    op(1, 0, 8'hb7, v);
    rd(8'hb7, v & 8'h7f);
    chk(erase_page_number, v & 8'h7f);
    op(1, 0, 8'hb2, 8'h41);
    rd(8'hb2, 8'h41);
    op(1, 0, 8'hb2, 8'h00);
    rd(8'hb2, 8'h40);
    prelude_active = 1;
    idle(4);
    rd(8'hb2, 8'hc0);
    op(1, 0, 8'hb2, 8'h42);
    op(1, 0, 8'h94, v);
    op(1, 0, 8'h94, 8'h00);
    idle(2);
    chk(8'(mass_n * 16 + page_n), 8'h11);
    op(1, 0, 8'hf8, 8'h80);
    idle(2);
    chk(8'(dog_n), 8'h01);
    {transfer_busy_irq, seconds_tick_irq, clk_lock_level} = 3'h7;
    {write_busy_collision, write_start_collision, button_pressed, autowake_event} = 4'hf;
    idle(2);
    {transfer_busy_irq, seconds_tick_irq} = 2'h0;
    {write_busy_collision, write_start_collision, button_pressed, autowake_event} = 4'h0;
    idle(5);
    clk_lock_level = 0;
    idle(5);
    rd(8'he8, 8'hff);
    op(1, 0, 8'he8, 8'hbe);
    rd(8'he8, 8'hbe);
    op(1, 0, 8'he8, 8'h00);
    rd(8'he8, 8'h00);
    ext_irq_levels = 7'($random(seed));
    idle(4);
    rd(8'hf8, {1'b0, ext_irq_levels});
    op(1, 0, 8'he8, 8'h00);
    transfer_busy_irq = 1;
    rd(8'he8, 8'h01);
    transfer_busy_irq = 0;
    v = 8'($random(seed));
    op(1, 0, 8'hb6, v);
    op(1, 0, 8'h9e, ~v);
    op(1, 0, 8'h9f, v);
    chk({5'h00, flash_bank_select}, {5'h00, v[2:0]});
    rd(8'hb6, {5'h00, v[2:0]});
    rd(8'h9e, ~v);
    rd(8'h9f, v);
    chk(eeprom_link_data, ~v);
    chk(eeprom_link_control, v);
    idle(3);
    final_report();
  end
  initial begin
    #20000;
    errors++;
    $display("[ERR] %0t watchdog timeout", $time);
    final_report();
  end
endmodule // test_sfb_sfr_bank
`default_nettype wire
